// File: hdl/cct_ctrl_regs.sv
// control, acknowledge-mask and configuration registers of the translator
//
// Overview of operation
// [RULE1] soft reset waits until transfers go idle
// [RULE2] soft reset restores every register default
// [RULE3] disabled: no acknowledge, no new transmit
// [RULE4] disabling waits for pending transfer to finish
// [RULE5] enabled: acknowledge only masked-in logical addresses
// [RULE6] host writes zero to upper mask top bit
// [RULE7] cleared mask bit: address not acknowledged
// [RULE8] set mask bit: acknowledge and forward message
// [RULE9] error enable: report via register and frame
// [RULE10] retry field saturates at five retries
// [RULE11] refused transmit confirmed with off-state code
// [RULE12] error frames only while error enable set
// [RULE13] low bit n address n, high n+8
`timescale 1ns/10ps
`default_nettype none
module cct_ctrl_regs (
    // clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_b_i,
    // register port from the host-side serial front end
    input  wire cct_pkg::cct_reg_req_t reg_req_i,
    output logic [7:0]                 reg_rdata_o,
    // line engine status
    input  wire logic                  cec_tx_busy_i,
    input  wire logic                  cec_rx_busy_i,
    // receive acknowledge decision
    input  wire logic [3:0]            rx_dest_i,
    output logic                       ack_o,
    output logic                       forward_o,
    // transmit requests
    input  wire logic                  tx_req_i,
    output logic                       tx_accept_o,
    output cct_pkg::cct_frame_t        cnf_o,
    // error events
    input  wire logic                  err_evt_i,
    input  wire logic                  err_with_msg_i,
    input  wire logic [7:0]            err_code_i,
    output cct_pkg::cct_frame_t        err_frame_o,
    output logic [7:0]                 err_detail_o,
    // settings for the rest of the device
    output logic                       dev_enabled_o,
    output logic [2:0]                 retry_limit_o,
    output logic                       soft_reset_o
);
    // register state
    logic       en_req_ff;
    logic       nxt_en_req;
    logic       en_eff_ff;
    logic       nxt_en_eff;
    logic       rst_pend_ff;
    logic       nxt_rst_pend;
    logic       soft_rst_ff;
    logic       nxt_soft_rst;
    logic [6:0] ack_mask_upper_ff;
    logic [6:0] nxt_ack_mask_upper;
    logic [7:0] ack_mask_lower_ff;
    logic [7:0] nxt_ack_mask_lower;
    logic [7:0] conf_ff;
    logic [7:0] nxt_conf;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    // frame and error state
    cct_pkg::cct_frame_t cnf_ff;
    cct_pkg::cct_frame_t nxt_cnf;
    cct_pkg::cct_frame_t errf_ff;
    cct_pkg::cct_frame_t nxt_errf;
    logic [7:0]          err_det_ff;
    logic [7:0]          nxt_err_det;

    logic       busy;
    logic       do_soft_rst;
    logic       err_en;
    logic [2:0] retry_fld;
    logic [2:0] retry_sat;
    logic       wr_ctrl;
    logic       wr_ack_mask_upper;
    logic       wr_ack_mask_lower;
    logic       wr_conf;
    // both masks as one vector, bit n is logical address n
    logic [cct_pkg::CCT_MASK_W-1:0] mask_all;

    assign mask_all = {ack_mask_upper_ff, ack_mask_lower_ff}; // [RULE13]
    assign busy      = cec_tx_busy_i | cec_rx_busy_i;
    assign err_en    = conf_ff[cct_pkg::CCT_CONF_ERR_BIT];
    assign retry_fld = conf_ff[cct_pkg::CCT_RETRY_MSB:0];
    // a pending soft reset only fires between transfers
    assign do_soft_rst = rst_pend_ff & ~busy; // [RULE1]

    assign wr_ctrl = reg_req_i.wr & (reg_req_i.addr == cct_pkg::CCT_ADDR_CTRL);
    assign wr_ack_mask_upper = reg_req_i.wr & (reg_req_i.addr == cct_pkg::CCT_ADDR_ACK_MASK_UPPER);
    assign wr_ack_mask_lower = reg_req_i.wr & (reg_req_i.addr == cct_pkg::CCT_ADDR_ACK_MASK_LOWER);
    assign wr_conf = reg_req_i.wr & (reg_req_i.addr == cct_pkg::CCT_ADDR_CONF);

    // register file next state
    always_comb begin
        nxt_en_req   = en_req_ff;
        nxt_en_eff   = en_eff_ff;
        nxt_rst_pend = rst_pend_ff;
        nxt_soft_rst = 1'b0;
        nxt_ack_mask_upper     = ack_mask_upper_ff;
        nxt_ack_mask_lower     = ack_mask_lower_ff;
        nxt_conf     = conf_ff;
        if (do_soft_rst) begin
            // restore defaults exactly as a power-up would
            nxt_soft_rst = 1'b1;
            nxt_rst_pend = 1'b0; // [RULE1]
            nxt_en_req   = cct_pkg::CCT_CTRL_RST_VAL[cct_pkg::CCT_CTRL_EN_BIT];
            nxt_en_eff   = cct_pkg::CCT_CTRL_RST_VAL[cct_pkg::CCT_CTRL_EN_BIT];
            nxt_ack_mask_upper     = cct_pkg::CCT_ACK_MASK_UPPER_RST_VAL[6:0]; // [RULE2]
            nxt_ack_mask_lower     = cct_pkg::CCT_ACK_MASK_LOWER_RST_VAL;      // [RULE2]
            nxt_conf     = cct_pkg::CCT_CONF_RST_VAL;      // [RULE2]
        end else begin
            if (wr_ctrl) begin
                nxt_en_req = reg_req_i.wdata[cct_pkg::CCT_CTRL_EN_BIT];
                // writing zero to the reset bit does not cancel a request
                if (reg_req_i.wdata[cct_pkg::CCT_CTRL_RST_BIT]) begin
                    nxt_rst_pend = 1'b1; // [RULE1]
                end
            end
            // top bit is held at zero by the host, not stored
            if (wr_ack_mask_upper) begin
                nxt_ack_mask_upper = reg_req_i.wdata[6:0]; // [RULE6]
            end
            if (wr_ack_mask_lower) begin
                nxt_ack_mask_lower = reg_req_i.wdata;
            end
            if (wr_conf) begin
                nxt_conf = reg_req_i.wdata;
            end
            // enabling is immediate, disabling waits for the line to idle
            if (nxt_en_req) begin
                nxt_en_eff = 1'b1;
            end else if (!busy) begin
                nxt_en_eff = 1'b0; // [RULE4]
            end
        end
    end

    // read data; unused control and upper-mask bits and unmapped offsets read zero, all configuration bits read back as written
    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                cct_pkg::CCT_ADDR_CTRL: nxt_rdata = {rst_pend_ff, en_req_ff,
                                                     6'h00};
                cct_pkg::CCT_ADDR_ACK_MASK_UPPER: nxt_rdata = {1'b0, ack_mask_upper_ff};
                cct_pkg::CCT_ADDR_ACK_MASK_LOWER: nxt_rdata = ack_mask_lower_ff;
                cct_pkg::CCT_ADDR_CONF: nxt_rdata = conf_ff;
                default:                nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            en_req_ff   <= cct_pkg::CCT_CTRL_RST_VAL[cct_pkg::CCT_CTRL_EN_BIT];
            en_eff_ff   <= cct_pkg::CCT_CTRL_RST_VAL[cct_pkg::CCT_CTRL_EN_BIT];
            rst_pend_ff <= 1'b0;
            soft_rst_ff <= 1'b0;
            ack_mask_upper_ff     <= cct_pkg::CCT_ACK_MASK_UPPER_RST_VAL[6:0];
            ack_mask_lower_ff     <= cct_pkg::CCT_ACK_MASK_LOWER_RST_VAL;
            conf_ff     <= cct_pkg::CCT_CONF_RST_VAL;
            rdata_ff    <= 8'h00;
        end else begin
            en_req_ff   <= nxt_en_req;
            en_eff_ff   <= nxt_en_eff;
            rst_pend_ff <= nxt_rst_pend;
            soft_rst_ff <= nxt_soft_rst;
            ack_mask_upper_ff     <= nxt_ack_mask_upper;
            ack_mask_lower_ff     <= nxt_ack_mask_lower;
            conf_ff     <= nxt_conf;
            rdata_ff    <= nxt_rdata;
        end
    end

    // acknowledge decision; an acknowledged message is also forwarded
    cct_ack_decode u_ack (
        .mask_i   (mask_all),
        .dest_i   (rx_dest_i),
        .enable_i (en_eff_ff), // [RULE3]
        .hit_o    (ack_o)      // [RULE7]
    );
    assign forward_o = ack_o; // [RULE8]

    // retry saturation
    assign retry_sat = (retry_fld > cct_pkg::CCT_RETRY_MAX) ?
                       cct_pkg::CCT_RETRY_MAX : retry_fld; // [RULE10]

    // transmit admission and confirmation, error reporting
    assign tx_accept_o = tx_req_i & en_eff_ff; // [RULE3]

    always_comb begin
        nxt_cnf     = '0;
        nxt_errf    = '0;
        nxt_err_det = err_det_ff;
        if (tx_req_i && !en_eff_ff) begin
            nxt_cnf.valid   = 1'b1;
            nxt_cnf.service = cct_pkg::CCT_SVC_CNF;
            nxt_cnf.code    = cct_pkg::CCT_RES_OFF; // [RULE11]
        end
        // errors are dropped silently while notification is off
        if (err_evt_i && err_en) begin
            nxt_errf.valid   = 1'b1; // [RULE12]
            nxt_errf.service = err_with_msg_i ? cct_pkg::CCT_SVC_IER :
                                                cct_pkg::CCT_SVC_ERR;
            nxt_errf.code    = err_code_i;
            nxt_err_det      = err_code_i; // [RULE9]
        end
        if (do_soft_rst) begin
            nxt_err_det = 8'h00;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            cnf_ff     <= '0;
            errf_ff    <= '0;
            err_det_ff <= 8'h00;
        end else begin
            cnf_ff     <= nxt_cnf;
            errf_ff    <= nxt_errf;
            err_det_ff <= nxt_err_det;
        end
    end

    assign reg_rdata_o   = rdata_ff;
    assign cnf_o         = cnf_ff;
    assign err_frame_o   = errf_ff;
    assign err_detail_o  = err_det_ff;
    assign dev_enabled_o = en_eff_ff;
    assign retry_limit_o = retry_sat;
    assign soft_reset_o  = soft_rst_ff;

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    AST_RST_DEFER: assert property ( // [RULE1]
        soft_reset_o |-> $past(rst_pend_ff) && !$past(busy))
        else $error("soft reset fired while a transfer was active");

    AST_RST_DEFAULTS: assert property ( // [RULE2]
        soft_reset_o |-> ack_mask_lower_ff == cct_pkg::CCT_ACK_MASK_LOWER_RST_VAL
            && conf_ff == cct_pkg::CCT_CONF_RST_VAL
            && !rst_pend_ff)
        else $error("soft reset left a register off its default");

    AST_OFF_NO_ACK: assert property ( // [RULE3]
        !dev_enabled_o |-> !ack_o && !tx_accept_o)
        else $error("disabled device acknowledged or accepted");

    AST_DISABLE_DEFER: assert property ( // [RULE4]
        en_eff_ff && busy && !do_soft_rst |=> en_eff_ff)
        else $error("device disabled during a pending transfer");

    AST_ACK_ONLY_MASKED: assert property ( // [RULE7]
        ack_o |-> rx_dest_i != cct_pkg::CCT_ADDR_BCAST
            && mask_all[rx_dest_i])
        else $error("acknowledged an address whose mask bit is clear");

    AST_ACK_FORWARD: assert property ( // [RULE8]
        en_eff_ff && rx_dest_i < 4'h8 && ack_mask_lower_ff[rx_dest_i[2:0]]
            |-> ack_o && forward_o)
        else $error("masked-in low address not acknowledged");

    AST_ACK_HIGH_MAP: assert property ( // [RULE13]
        en_eff_ff && rx_dest_i >= 4'h8 && ack_o |-> ack_mask_upper_ff[rx_dest_i[2:0]])
        else $error("high mask bit mapped to wrong address");

    AST_RETRY_SAT: assert property ( // [RULE10]
        retry_limit_o <= cct_pkg::CCT_RETRY_MAX
            && (retry_fld <= cct_pkg::CCT_RETRY_MAX
                ? retry_limit_o == retry_fld : retry_limit_o == 3'h5))
        else $error("retry count not saturated at five");

    AST_REFUSE_CNF: assert property ( // [RULE11]
        tx_req_i && !en_eff_ff |=> cnf_o.valid
            && cnf_o.code == cct_pkg::CCT_RES_OFF)
        else $error("refused transmit lacked off-state confirmation");

    AST_ERR_GATE: assert property ( // [RULE12]
        err_frame_o.valid |-> $past(err_evt_i) && $past(err_en))
        else $error("error frame sent with notification disabled");

    AST_ERR_REPORT: assert property ( // [RULE9]
        err_evt_i && err_en && !do_soft_rst |=> err_frame_o.valid
            && err_detail_o == $past(err_code_i))
        else $error("enabled error not reported");

    COV_SOFT_RST_WAIT: cover property (
        rst_pend_ff && busy ##1 rst_pend_ff [*2] ##[1:20] soft_reset_o);
    COV_REFUSE: cover property (cnf_o.valid);
    COV_ERR_IER: cover property (
        err_frame_o.valid && err_frame_o.service == cct_pkg::CCT_SVC_IER);
    COV_ACK_HIGH: cover property (ack_o && rx_dest_i == 4'he);
endmodule // cct_ctrl_regs
`default_nettype wire

// File: hdl/cct_pkg.sv
// constants and carrier types for the translator control registers
package cct_pkg;

    // register offsets
    localparam logic [4:0] CCT_ADDR_CTRL = 5'h03;
    localparam logic [4:0] CCT_ADDR_ACK_MASK_UPPER = 5'h04;
    localparam logic [4:0] CCT_ADDR_ACK_MASK_LOWER = 5'h05;
    localparam logic [4:0] CCT_ADDR_CONF = 5'h06;

    // field positions
    localparam int CCT_CTRL_RST_BIT = 7;
    localparam int CCT_CTRL_EN_BIT  = 6;
    localparam int CCT_CONF_ERR_BIT = 4;
    localparam int CCT_RETRY_MSB    = 2;
    localparam int CCT_ACK_MASK_UPPER_MSB     = 6;

    // values after reset
    localparam logic [7:0] CCT_CTRL_RST_VAL = 8'h00;
    localparam logic [7:0] CCT_ACK_MASK_UPPER_RST_VAL = 8'h00;
    localparam logic [7:0] CCT_ACK_MASK_LOWER_RST_VAL = 8'h00;
    localparam logic [7:0] CCT_CONF_RST_VAL = 8'h00;

    // retry ceiling and the one logical address that has no mask bit
    localparam logic [2:0] CCT_RETRY_MAX  = 3'h5;
    localparam logic [3:0] CCT_ADDR_BCAST = 4'hf;
    localparam int         CCT_MASK_W     = 15;

    // frame service selectors and result codes
    localparam logic [7:0] CCT_SVC_CNF = 8'h01;
    localparam logic [7:0] CCT_SVC_ERR = 8'h82;
    localparam logic [7:0] CCT_SVC_IER = 8'h83;
    localparam logic [7:0] CCT_RES_OFF = 8'h80;
    localparam logic [7:0] CCT_RES_OK  = 8'h00;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } cct_reg_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] service;
        logic [7:0] code;
    } cct_frame_t;

endpackage

// File: hdl/cct_ack_decode.sv
// per-address acknowledge decode from the two mask registers
`timescale 1ns/10ps
`default_nettype none
module cct_ack_decode (
    // mask, destination and enable
    input  wire logic [cct_pkg::CCT_MASK_W-1:0] mask_i,
    input  wire logic [3:0]                     dest_i,
    input  wire logic                           enable_i,
    // decision
    output logic                                hit_o
);
    logic [cct_pkg::CCT_MASK_W-1:0] sel;

    // address 15 has no mask bit, so it is never matched
    genvar gi;
    generate
        for (gi = 0; gi < cct_pkg::CCT_MASK_W; gi++) begin : g_addr
            assign sel[gi] = mask_i[gi] & (dest_i == 4'(gi)); // [RULE13]
        end
    endgenerate

    assign hit_o = enable_i & (|sel); // [RULE5]
endmodule // cct_ack_decode
`default_nettype wire

// File: tb/cct_host_model.sv
// host-side register master model for the control register bench
`timescale 1ns/10ps
`default_nettype none
module cct_host_model (
    // clock
    input  wire logic             ref_clk_i,
    // register port
    output cct_pkg::cct_reg_req_t reg_req_o,
    input  wire logic [7:0]       reg_rdata_i
);
    initial reg_req_o = '0;

    // released bus flips, so a stale value never looks valid
    task automatic idle();
        reg_req_o <= '{1'b0, 1'b0, ~reg_req_o.addr, ~reg_req_o.wdata};
        #1;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        if (a == cct_pkg::CCT_ADDR_ACK_MASK_UPPER) begin
            d[7] = 1'b0;
        end
        reg_req_o <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk_i);
        idle();
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        reg_req_o <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk_i);
        idle();
        d = reg_rdata_i;
    endtask
endmodule // cct_host_model
`default_nettype wire

// File: tb/cec_translator_control_regs_bench.sv
// self-checking bench for the translator control registers
`timescale 1ns/10ps
`default_nettype none
module cec_translator_control_regs_bench;
    logic                  ref_clk_i = 1'b0;
    logic                  rst_b_i, tx_busy, rx_busy, tx_req;
    logic                  err_evt, err_msg, ack, fwd, accept, en, srst;
    logic [3:0]            dest;
    logic [7:0]            err_code, rdata, detail;
    logic [2:0]            retry;
    cct_pkg::cct_reg_req_t req;
    cct_pkg::cct_frame_t   cnf, efr;
    int                    err_count, check_count, cyc;

    cct_host_model i_cct_host_model (.ref_clk_i(ref_clk_i),
        .reg_req_o(req), .reg_rdata_i(rdata));
    cct_ctrl_regs i_cct_ctrl_regs (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .reg_req_i(req), .reg_rdata_o(rdata), .cec_tx_busy_i(tx_busy),
        .cec_rx_busy_i(rx_busy), .rx_dest_i(dest), .ack_o(ack),
        .forward_o(fwd), .tx_req_i(tx_req), .tx_accept_o(accept),
        .cnf_o(cnf), .err_evt_i(err_evt), .err_with_msg_i(err_msg),
        .err_code_i(err_code), .err_frame_o(efr), .err_detail_o(detail),
        .dev_enabled_o(en), .retry_limit_o(retry), .soft_reset_o(srst));

    initial forever #5 ref_clk_i = ~ref_clk_i;

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // hang guard, well above the fewer than 200 cycles the tests need
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic chk(input string      n,
                       input logic [16:0] s,
                       input logic [16:0] e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic go(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic rchk(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_cct_host_model.rd(a, d);
        chk("rdata", 17'(d), 17'(e));
    endtask

    task automatic t_regs();
        for (int a = 3; a < 7; a++) rchk(5'(a), 8'h00);
        i_cct_host_model.wr(5'h01, 8'hff);
        rchk(5'h01, 8'h00);
        i_cct_host_model.wr(cct_pkg::CCT_ADDR_ACK_MASK_UPPER, 8'hff);
        rchk(cct_pkg::CCT_ADDR_ACK_MASK_UPPER, 8'h7f);
        for (int v = 0; v < 8; v++) begin
            i_cct_host_model.wr(cct_pkg::CCT_ADDR_CONF, 8'(8'he8 + v));
            chk("retry", 17'(retry), 17'(v > 5 ? 5 : v));
            rchk(cct_pkg::CCT_ADDR_CONF, 8'(8'he8 + v));
        end
        $display("test regs done");
    endtask

    task automatic t_ack();
        logic [14:0] m;
        logic        xp;
        m = {7'h5a, 8'ha5};
        i_cct_host_model.wr(cct_pkg::CCT_ADDR_ACK_MASK_LOWER, 8'ha5);
        i_cct_host_model.wr(cct_pkg::CCT_ADDR_ACK_MASK_UPPER, 8'h5a);
        i_cct_host_model.wr(cct_pkg::CCT_ADDR_CTRL, 8'h40);
        for (int d = 0; d < 16; d++) begin
            @(posedge ref_clk_i) dest <= 4'(d);
            go(0);
            #1;
            // address 15 has no mask bit and is never acknowledged
            xp = (d == 15) ? 1'b0 : m[d];
            chk("ack", 17'(ack), 17'(xp));
            chk("fwd", 17'(fwd), 17'(xp));
        end
        @(posedge ref_clk_i) dest <= 4'h0;
        i_cct_host_model.wr(cct_pkg::CCT_ADDR_CTRL, 8'h00);
        go(2);
        chk("ack off", 17'(ack), 17'h0);
        $display("test ack done");
    endtask

    task automatic txp(input logic e);
        @(posedge ref_clk_i) tx_req <= 1'b1;
        #1;
        chk("accept", 17'(accept), 17'(e));
        @(posedge ref_clk_i) tx_req <= 1'b0;
        #1;
        chk("cnf", cnf, e ? 17'h0 : {1'b1, 8'h01, 8'h80});
        go(1);
        chk("cnf end", 17'(cnf.valid), 17'h0);
    endtask

    task automatic t_tx_dis();
        int n;
        txp(1'b0);
        i_cct_host_model.wr(cct_pkg::CCT_ADDR_CTRL, 8'h40);
        go(1);
        txp(1'b1);
        @(posedge ref_clk_i) rx_busy <= 1'b1;
        i_cct_host_model.wr(cct_pkg::CCT_ADDR_CTRL, 8'h00);
        go(3);
        chk("en busy", 17'(en), 17'h1);
        @(posedge ref_clk_i) rx_busy <= 1'b0;
        for (n = 0; n < 4 && en; n++) go(1);
        chk("en idle", 17'(en), 17'h0);
        $display("test tx and disable done");
    endtask

    task automatic errp(input logic k, input logic [7:0] c);
        @(posedge ref_clk_i) begin
            err_evt <= 1'b1;
            err_msg <= k;
            err_code <= c;
        end
        @(posedge ref_clk_i) err_evt <= 1'b0;
        #1;
    endtask

    task automatic t_err();
        i_cct_host_model.wr(cct_pkg::CCT_ADDR_CONF, 8'h00);
        errp(1'b0, 8'h03);
        chk("no frame", 17'(efr.valid), 17'h0);
        chk("detail", 17'(detail), 17'h0);
        i_cct_host_model.wr(cct_pkg::CCT_ADDR_CONF, 8'h10);
        for (int k = 0; k < 2; k++) begin
            errp(k[0], 8'(2 + k));
            chk("frame", efr, {1'b1, 8'(8'h82 + k), 8'(2 + k)});
            chk("detail", 17'(detail), 17'(2 + k));
        end
        $display("test err done");
    endtask

    task automatic t_srst();
        int n;
        i_cct_host_model.wr(cct_pkg::CCT_ADDR_ACK_MASK_LOWER, 8'h3c);
        @(posedge ref_clk_i) tx_busy <= 1'b1;
        i_cct_host_model.wr(cct_pkg::CCT_ADDR_CTRL, 8'hc0);
        go(4);
        chk("early", 17'(srst), 17'h0);
        rchk(cct_pkg::CCT_ADDR_CTRL, 8'hc0);
        @(posedge ref_clk_i) tx_busy <= 1'b0;
        for (n = 0; n < 5 && !srst; n++) go(1);
        chk("srst", 17'(srst), 17'h1);
        chk("en", 17'(en), 17'h0);
        chk("detail", 17'(detail), 17'h0);
        go(1);
        chk("srst end", 17'(srst), 17'h0);
        for (int a = 3; a < 7; a++) rchk(5'(a), 8'h00);
        $display("test soft reset done");
    endtask

    initial begin
        rst_b_i = 1'b0;
        {tx_busy, rx_busy, tx_req, err_evt, err_msg} = '0;
        dest = 4'h0;
        err_code = 8'h00;
        repeat (5) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        t_regs();
        t_ack();
        t_tx_dis();
        t_err();
        t_srst();
        stop_test();
    end
endmodule // cec_translator_control_regs_bench
`default_nettype wire
